// File: cpf_host_model.sv
/*
  Host model for the SPI control port: drives bit clock, frame latch and data.
  Assumes the bench resolves the shared pins and hands in the readback line.
*/
`timescale 1ns/10ps

module cpf_host_model (
  input wire logic miso,
  input wire logic miso_oe,
  output logic sck,
  output logic latch,
  output logic mosi
);
  logic last_bit;

  // The clock parks high between frames, where the pull-up would leave it.
  initial begin
    sck = 1'b1;
    latch = 1'b1;
    mosi = 1'b0;
    last_bit = 1'b0;
  end

  // Sends n bits MSB first; a released readback line shows the inverse of its last bit.
  task automatic shift(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    latch = 1'b0;
    #20;
    for (int i = n - 1; i >= 0; i--) begin
      sck = 1'b0;
      mosi = tx[i];
      #15;
      sck = 1'b1;
      rx[i] = miso_oe ? miso : ~last_bit;
      last_bit = rx[i];
      #15;
    end
    latch = 1'b1;
    #60;
  endtask

  // One latch pulse, each phase longer than three core clocks.
  task automatic pulse();
    latch = 1'b0;
    #40;
    latch = 1'b1;
    #40;
  endtask
endmodule

// File: cpf_mp_pin.sv
/*
  One multipurpose pin: GPIO input or output, or an alternate role (a second one where HAS_ALT_B is set).
  Assumes mode and output values come from logic on the core clock.
*/
`timescale 1ns/10ps

module cpf_mp_pin
  import cpf_pkg::*;
#(
  parameter bit ALT_IS_OUT = 1'b0,
  parameter bit HAS_ALT_B = 1'b0
) (
  input wire logic clock,
  input wire logic srst,
  input wire cpf_mp_mode_t mode,
  input wire logic gpio_out,
  input wire logic alt_a_out,
  input wire logic alt_b_out,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_in_sync
);

  // Input roles, including aux ADC and serial input, are seen through the synchroniser.
  cpf_sync #(.W(1)) u_sync (
    .clock(clock),
    .srst(srst),
    .d(pin_in),
    .q(pin_in_sync)
  );

  // A role the pin does not have falls back to a plain input, so it never fights a driver.
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      case (mode)
        MP_GPIO_OUT: begin
          pin_out <= gpio_out;
          pin_oe <= 1'b1;
        end
        MP_ALT_A: begin
          pin_out <= alt_a_out;
          pin_oe <= ALT_IS_OUT;
        end
        MP_ALT_B: begin
          pin_out <= alt_b_out;
          pin_oe <= ALT_IS_OUT & HAS_ALT_B;
        end
        default: begin
          pin_out <= 1'b0;
          pin_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: cpf_params.svh
/*
  Constants for the control port pin front end: timing counts and fixed values.
  Assumes it is included by bare name from the package and the bench.
*/
`ifndef CPF_PARAMS_SVH
`define CPF_PARAMS_SVH

// Core clock period in ns.
`define CPF_CLK_PERIOD_NS 8
// Internal clock cycles from reset release to the end of initialization.
`define CPF_INIT_CYCLES 2048
// Least high or low time of the boot I2C clock in ns.
`define CPF_SCL_HALF_NS 5000
// Half period of the boot I2C clock in core cycles, rounded up.
`define CPF_SCL_HALF_CYC ((`CPF_SCL_HALF_NS + `CPF_CLK_PERIOD_NS - 1) / `CPF_CLK_PERIOD_NS)
// I2C clock periods spent loading from the EEPROM and writing back to it.
`define CPF_BOOT_SCL_CYCLES 256
`define CPF_WB_SCL_CYCLES 256
// Low pulses on the frame latch that switch the port to SPI.
`define CPF_LATCH_PULSES_TO_SPI 3
// Header bytes ahead of the first data byte: chip address and two subaddress bytes.
`define CPF_HDR_BYTES 3
// Upper bits of the bus address; the select pins fill the low bits.
`define CPF_I2C_ADDR_BASE 7'h00
// Multipurpose pins whose alternate role is an output.
`define CPF_MP_ALT_OUT_MASK 12'hcc0
// Pin that also offers the TDM data output.
`define CPF_MP_TDM_PIN 6

`endif

// File: cpf_pkg.sv
/*
  Types shared by the control port pin front end.
  Assumes cpf_params.svh is on the include path.
*/
`include "cpf_params.svh"

package cpf_pkg;

  // Sequence from reset to normal operation.
  typedef enum logic [4:0] {
    ST_RESET = 5'b00001,
    ST_INIT  = 5'b00010,
    ST_BOOT  = 5'b00100,
    ST_RUN   = 5'b01000,
    ST_WB    = 5'b10000
  } cpf_state_t;

  // Role of a multipurpose pin.
  typedef enum logic [1:0] {
    MP_GPIO_IN  = 2'h0,
    MP_GPIO_OUT = 2'h1,
    MP_ALT_A    = 2'h2,
    MP_ALT_B    = 2'h3
  } cpf_mp_mode_t;

  // One byte received over SPI, with its place in the frame.
  typedef struct packed {
    logic is_read;
    logic [7:0] index;
    logic [7:0] data;
  } cpf_rx_byte_t;

  // Output side of an open-drain or two-way pad.
  typedef struct packed {
    logic out;
    logic oe;
  } cpf_pad_t;

endpackage

// File: cpf_sync.sv
/*
  Two flip-flop synchroniser for levels entering the core clock domain.
  Assumes each bit is an independent level; words need their own crossing.
*/
`timescale 1ns/10ps

module cpf_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock) begin
    if (srst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;

endmodule

// File: cpf_top.sv
/*
  Control port pin front end: reset initialization, boot source, I2C pad control,
  SPI receive and readback on the SPI bit clock, and the multipurpose pin roles.
  Assumes the pads combine out and oe into the wire, and that readback data is
  answered by core logic well within one SPI byte time.
*/
// Summary of operation
// - I2C control mode: clock pin never driven.
// - Self-boot drives the I2C clock as master.
// - I2C data pin both received and driven.
// - SPI output released unless read data returns.
// - Frame length follows the header bytes.
// - Bus address comes from select pins.
// - After reset release, load memories from ROM.
// - Initialization clears registers and data memory.
// - Initialization lasts a fixed cycle count.
// - Boot-source pin picks self-boot or host.
// - Multipurpose pins: serial, aux ADC, GPIO roles.
// - Four pins: GPIO or serial input roles.
// - Output pins: GPIO, serial output or TDM.
// - Four pins: GPIO or aux ADC inputs.
// - Latch pin is EEPROM write protect in self-boot.
// - Address-select pin also data in and write-back.
// - SPI input captured on bit clock rise.
// - Readback shifted on fall, sampled on rise.
// - Start in I2C; three latch lows select SPI.
// - First byte: chip address, read flag LSB.
`timescale 1ns/10ps

module cpf_top
  import cpf_pkg::*;
#(
  parameter int INIT_CYCLES = `CPF_INIT_CYCLES,
  parameter int SCL_HALF_CYC = `CPF_SCL_HALF_CYC,
  parameter int BOOT_SCL_CYCLES = `CPF_BOOT_SCL_CYCLES,
  parameter int WB_SCL_CYCLES = `CPF_WB_SCL_CYCLES,
  parameter int MP_PINS = 12
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic active_low_reset_pin,
  input wire logic selfboot_pin,
  input wire logic bus_addr_select_lo,
  input wire logic bus_addr_select_hi,
  input wire logic spi_bit_clock,
  input wire logic spi_frame_latch,
  input wire logic sda_in,
  input wire logic sda_pull_low,
  input wire logic [7:0] rd_data,
  input wire cpf_mp_mode_t [MP_PINS-1:0] mp_mode,
  input wire logic [MP_PINS-1:0] mp_gpio_out,
  input wire logic [MP_PINS-1:0] mp_alt_out,
  input wire logic mp_tdm_out,
  input wire logic [MP_PINS-1:0] mp_in,
  output logic [MP_PINS-1:0] mp_out,
  output logic [MP_PINS-1:0] mp_oe,
  output logic [MP_PINS-1:0] mp_in_sync,
  output cpf_pad_t scl_pad,
  output cpf_pad_t sda_pad,
  output cpf_pad_t wp_pad,
  output logic spi_serial_out,
  output logic spi_serial_out_oe,
  output logic scl_in_sync,
  output logic sda_in_sync,
  output logic [6:0] i2c_addr,
  output logic ctrl_spi_mode,
  output logic init_busy,
  output logic eeprom_boot,
  output logic eeprom_writeback,
  output cpf_rx_byte_t rx_byte,
  output logic rx_valid,
  output logic rd_req,
  output logic frame_end
);

  cpf_state_t state_r;
  logic [15:0] init_cnt_r;
  logic [15:0] scl_div_r;
  logic [15:0] scl_cnt_r;
  logic scl_lvl_r;
  logic scl_done;
  logic selfboot_r;
  logic [1:0] latch_falls_r;
  logic latch_d_r;
  logic wb_d_r;
  logic tgl_d_r;
  logic rdt_d_r;
  logic [6:0] spi_chip_addr_r;
  logic [7:0] rb_r;
  logic rst_pin_s;
  logic boot_s;
  logic sel_lo_s;
  logic sel_hi_s;
  logic latch_s;
  logic tgl_s;
  logic rdt_s;
  logic spi_abort;
  logic [2:0] bit_idx_r;
  logic [7:0] byte_cnt_r;
  logic [6:0] shift_in_r;
  logic [7:0] shift_out_r;
  logic [7:0] spi_data_r;
  logic [7:0] spi_idx_r;
  logic hdr_read_r;
  logic hdr_match_r;
  logic byte_tgl_r;
  logic rd_tgl_r;
  logic [7:0] rx_now;
  logic spi_serial_in;
  logic wb_s;
  logic spi_rst;
  logic spi_rd_r;

  // Every pin and cross-domain toggle that the core clock reads passes two flip-flops before use.
  cpf_sync #(.W(10)) u_pins (
    .clock(clock),
    .srst(srst),
    .d({active_low_reset_pin, selfboot_pin, bus_addr_select_lo, bus_addr_select_hi,
        spi_frame_latch, byte_tgl_r, rd_tgl_r, spi_bit_clock, sda_in, spi_serial_in}),
    .q({rst_pin_s, boot_s, sel_lo_s, sel_hi_s, latch_s, tgl_s, rdt_s, scl_in_sync,
        sda_in_sync, wb_s})
  );

  // The address-select pin doubles as SPI data in and write-back trigger.
  assign spi_serial_in = bus_addr_select_hi;

  // Boot clock stops after its last full low phase, at the end of the high that follows.
  assign scl_done = (scl_div_r == 16'(SCL_HALF_CYC - 1)) && scl_lvl_r &&
                    (scl_cnt_r == 16'((state_r == ST_WB) ? WB_SCL_CYCLES
                                                         : BOOT_SCL_CYCLES));

  // Reset, initialization, boot and write-back sequence.
  always_ff @(posedge clock) begin
    if (srst || !rst_pin_s) begin
      state_r <= ST_RESET;
    end else begin
      case (state_r)
        ST_RESET: state_r <= ST_INIT;
        ST_INIT: begin
          if (init_cnt_r == 16'(INIT_CYCLES - 1)) begin
            state_r <= boot_s ? ST_BOOT : ST_RUN;
          end
        end
        ST_BOOT: state_r <= scl_done ? ST_RUN : ST_BOOT;
        ST_RUN: begin
          if (selfboot_r && wb_s && !wb_d_r) begin
            state_r <= ST_WB;
          end
        end
        ST_WB: state_r <= scl_done ? ST_RUN : ST_WB;
        default: state_r <= ST_RESET;
      endcase
    end
  end

  // Initialization counter runs from the synchronised reset release.
  always_ff @(posedge clock) begin
    if (srst || state_r != ST_INIT) begin
      init_cnt_r <= 16'h0000;
    end else begin
      init_cnt_r <= init_cnt_r + 16'h0001;
    end
  end

  // Boot source and bus address captured as initialization ends; busy status follows the state.
  always_ff @(posedge clock) begin
    if (srst || !rst_pin_s) begin
      selfboot_r <= 1'b0;
      i2c_addr <= 7'h00;
      spi_chip_addr_r <= 7'h00;
      init_busy <= !srst;
    end else begin
      init_busy <= (state_r == ST_RESET) || (state_r == ST_INIT);
      if (state_r == ST_INIT && init_cnt_r == 16'(INIT_CYCLES - 1)) begin
        selfboot_r <= boot_s;
        i2c_addr <= `CPF_I2C_ADDR_BASE | {5'h00, sel_hi_s, sel_lo_s};
        spi_chip_addr_r <= {6'h00, sel_lo_s};
      end
    end
  end

  // Boot clock divider; only the self-boot states ever advance it.
  always_ff @(posedge clock) begin
    if (srst || (state_r != ST_BOOT && state_r != ST_WB)) begin
      scl_div_r <= 16'h0000;
      scl_cnt_r <= 16'h0000;
      scl_lvl_r <= 1'b1;
    end else if (scl_div_r == 16'(SCL_HALF_CYC - 1)) begin
      scl_div_r <= 16'h0000;
      scl_lvl_r <= !scl_lvl_r;
      if (scl_lvl_r) begin
        scl_cnt_r <= scl_cnt_r + 16'h0001;
      end
    end else begin
      scl_div_r <= scl_div_r + 16'h0001;
    end
  end

  // Open-drain pads: drive low only, release for high; the write-protect pad drives both levels.
  always_ff @(posedge clock) begin
    if (srst) begin
      scl_pad <= '0;
      sda_pad <= '0;
      wp_pad <= '0;
      eeprom_boot <= 1'b0;
      eeprom_writeback <= 1'b0;
    end else begin
      scl_pad.out <= 1'b0;
      // As a slave the clock pin stays an input; as boot master it is driven.
      scl_pad.oe <= (state_r == ST_BOOT || state_r == ST_WB) && !scl_lvl_r;
      sda_pad.out <= 1'b0;
      sda_pad.oe <= sda_pull_low && !ctrl_spi_mode && rst_pin_s;
      // Write protect stays high except while parameters are written back.
      wp_pad.out <= (state_r != ST_WB);
      wp_pad.oe <= selfboot_r;
      eeprom_boot <= (state_r == ST_BOOT);
      eeprom_writeback <= (state_r == ST_WB);
    end
  end

  // Mode switch counts latch low pulses from a host after initialization.
  always_ff @(posedge clock) begin
    if (srst || !rst_pin_s) begin
      latch_falls_r <= 2'h0;
      ctrl_spi_mode <= 1'b0;
      latch_d_r <= 1'b1;
      wb_d_r <= 1'b0;
    end else begin
      latch_d_r <= latch_s;
      wb_d_r <= wb_s;
      if (state_r == ST_RUN && !selfboot_r && !ctrl_spi_mode && latch_d_r && !latch_s) begin
        if (latch_falls_r == 2'(`CPF_LATCH_PULSES_TO_SPI - 1)) begin
          ctrl_spi_mode <= 1'b1;
        end
        latch_falls_r <= latch_falls_r + 2'h1;
      end
    end
  end

  assign rx_now = spi_data_r;

  // Byte events and read requests from the SPI domain, taken only when running.
  always_ff @(posedge clock) begin
    if (srst || !rst_pin_s) begin
      tgl_d_r <= 1'b0;
      rdt_d_r <= 1'b0;
      rx_valid <= 1'b0;
      rx_byte <= '0;
      rd_req <= 1'b0;
      frame_end <= 1'b0;
      rb_r <= 8'h00;
    end else begin
      tgl_d_r <= tgl_s;
      rdt_d_r <= rdt_s;
      // Before initialization ends, received bytes are dropped.
      rx_valid <= (tgl_s != tgl_d_r) && state_r == ST_RUN && ctrl_spi_mode;
      if (tgl_s != tgl_d_r) begin
        rx_byte <= '{is_read: spi_rd_r, index: spi_idx_r, data: rx_now};
      end
      rd_req <= (rdt_s != rdt_d_r) && state_r == ST_RUN && ctrl_spi_mode;
      frame_end <= ctrl_spi_mode && latch_s && !latch_d_r;
      if (rd_req) begin
        rb_r <= rd_data;
      end
    end
  end

  // The frame latch high, or the reset pin low, clears the SPI frame state; only the reset pin clears byte data and toggles.
  assign spi_abort = spi_frame_latch || !active_low_reset_pin;
  assign spi_rst = !active_low_reset_pin;

  // Receive side on bit clock rises; nothing here relies on a free-running clock.
  always_ff @(posedge spi_bit_clock or posedge spi_abort) begin
    if (spi_abort) begin
      bit_idx_r <= 3'h0;
      byte_cnt_r <= 8'h00;
      shift_in_r <= 7'h00;
      hdr_read_r <= 1'b0;
      hdr_match_r <= 1'b0;
    end else begin
      shift_in_r <= {shift_in_r[5:0], spi_serial_in};
      bit_idx_r <= bit_idx_r + 3'h1;
      if (bit_idx_r == 3'h7) begin
        if (byte_cnt_r != 8'hff) begin
          byte_cnt_r <= byte_cnt_r + 8'h01;
        end
        if (byte_cnt_r == 8'h00) begin
          hdr_read_r <= spi_serial_in;
          hdr_match_r <= (shift_in_r == spi_chip_addr_r);
        end
      end
    end
  end

  // Completed bytes leave as toggles; the data outlives the latch so the last byte is kept.
  always_ff @(posedge spi_bit_clock or posedge spi_rst) begin
    if (spi_rst) begin
      spi_data_r <= 8'h00;
      spi_idx_r <= 8'h00;
      spi_rd_r <= 1'b0;
    end else if (bit_idx_r == 3'h7) begin
      spi_data_r <= {shift_in_r, spi_serial_in};
      spi_idx_r <= byte_cnt_r;
      spi_rd_r <= (byte_cnt_r == 8'h00) ? spi_serial_in : hdr_read_r;
    end
  end

  // Only the reset pin clears the toggles, while the core side is held in reset as well.
  always_ff @(posedge spi_bit_clock or posedge spi_rst) begin
    if (spi_rst) begin
      byte_tgl_r <= 1'b0;
      rd_tgl_r <= 1'b0;
    end else if (bit_idx_r == 3'h7 && !spi_abort) begin
      byte_tgl_r <= !byte_tgl_r;
      if (byte_cnt_r != 8'h00 && hdr_read_r && hdr_match_r) begin
        rd_tgl_r <= !rd_tgl_r;
      end
    end
  end

  // Readback shifts on falls; the line is released until the first data byte.
  always_ff @(negedge spi_bit_clock or posedge spi_abort) begin
    if (spi_abort) begin
      shift_out_r <= 8'h00;
      spi_serial_out_oe <= 1'b0;
    end else if (bit_idx_r == 3'h0 && byte_cnt_r >= 8'(`CPF_HDR_BYTES) && hdr_read_r &&
                 hdr_match_r && ctrl_spi_mode) begin
      shift_out_r <= rb_r;
      spi_serial_out_oe <= 1'b1;
    end else begin
      shift_out_r <= {shift_out_r[6:0], 1'b0};
    end
  end

  assign spi_serial_out = shift_out_r[7];

  // Pins 0,1,4,5 serial in; 2,3,8,9 aux ADC; 6,7,10,11 serial out, 6 also TDM.
  for (genvar i = 0; i < MP_PINS; i++) begin : g_mp
    cpf_mp_pin #(
      .ALT_IS_OUT(1'((`CPF_MP_ALT_OUT_MASK >> i) & 1)),
      .HAS_ALT_B(i == `CPF_MP_TDM_PIN)
    ) u_mp (
      .clock(clock),
      .srst(srst),
      .mode(mp_mode[i]),
      .gpio_out(mp_gpio_out[i]),
      .alt_a_out(mp_alt_out[i]),
      .alt_b_out(mp_tdm_out),
      .pin_in(mp_in[i]),
      .pin_out(mp_out[i]),
      .pin_oe(mp_oe[i]),
      .pin_in_sync(mp_in_sync[i])
    );
  end

  AST_SCL_HOST_INPUT: assert property (@(posedge clock) disable iff (srst)
    state_r == ST_RUN |=> !scl_pad.oe) else $error("Clock pin driven in slave mode.");

  AST_SCL_BOOT_TOGGLE: assert property (@(posedge clock) disable iff (srst)
    (state_r == ST_BOOT && scl_div_r == 16'(SCL_HALF_CYC - 1)) |=> $changed(scl_lvl_r))
    else $error("Boot clock did not toggle.");

  AST_SDA_DRIVE: assert property (@(posedge clock) disable iff (srst)
    (sda_pull_low && !ctrl_spi_mode && rst_pin_s) |=> sda_pad.oe)
    else $error("Data pin not driven on request.");

  AST_SPI_SERIAL_OUT_READ_ONLY: assert property (@(negedge spi_bit_clock) disable iff (spi_abort)
    spi_serial_out_oe |-> (hdr_read_r && hdr_match_r && byte_cnt_r >= 8'(`CPF_HDR_BYTES)))
    else $error("Readback driven outside a read.");

  AST_INIT_LENGTH: assert property (@(posedge clock) disable iff (srst)
    $fell(state_r == ST_INIT) && rst_pin_s |-> $past(init_cnt_r) == 16'(INIT_CYCLES - 1))
    else $error("Initialization length wrong.");

  AST_BOOT_SOURCE: assert property (@(posedge clock) disable iff (srst)
    (state_r == ST_INIT && init_cnt_r == 16'(INIT_CYCLES - 1) && rst_pin_s)
    |=> (state_r == ST_BOOT) == $past(boot_s)) else $error("Wrong boot source taken.");

  AST_RESET_QUIET: assert property (@(posedge clock) disable iff (srst)
    !rst_pin_s |=> (state_r == ST_RESET && !rx_valid && !rd_req))
    else $error("Activity during reset.");

  AST_SPI_AFTER_THREE: assert property (@(posedge clock) disable iff (srst)
    $rose(ctrl_spi_mode) |-> $past(latch_falls_r) == 2'(`CPF_LATCH_PULSES_TO_SPI - 1))
    else $error("SPI mode after wrong pulse count.");

  AST_WP_SELFBOOT: assert property (@(posedge clock) disable iff (srst)
    (state_r == ST_WB) |=> (!wp_pad.out && wp_pad.oe)) else $error("Write protect wrong.");

  AST_BUSY_INIT: assert property (@(posedge clock) disable iff (srst)
    (state_r == ST_INIT && rst_pin_s) |=> init_busy) else $error("Busy not shown in init.");

endmodule

// File: tb_control_port_pin_frontend.sv
/*
  Self-checking bench for the control port pin front end.
  Assumes cpf_top run with short counts and the host model on the SPI pins.
*/
`timescale 1ns/10ps
`include "cpf_params.svh"

module tb_control_port_pin_frontend;
  import cpf_pkg::*;
  localparam int INIT = 16;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic rst_pin_n = 1'b1;
  logic selfboot = 1'b0;
  logic lo = 1'b1;
  logic hi_lvl = 1'b0;
  logic pull = 1'b0;
  cpf_mp_mode_t [11:0] mode;
  logic [11:0] gout = 12'ha5c;
  logic [11:0] aout = 12'h3f0;
  logic tdm = 1'b1;
  logic [11:0] pin_in = 12'h96a;
  logic [11:0] mp_out, mp_oe, mp_sync;
  cpf_pad_t scl_pad, sda_pad, wp_pad;
  cpf_rx_byte_t rxb;
  cpf_rx_byte_t rxq[$];
  logic [6:0] addr;
  logic sout, sout_oe, scl_sync, sda_sync, spi_mode, busy, boot, wb, rxv, rd_req, fend;
  logic h_sck, h_latch, h_mosi, oe_seen;
  logic [31:0] r;
  int error_cnt = 0;
  int cmp_count = 0;
  int rd_cnt = 0;
  int fe_cnt = 0;

  // Shared pins: open-drain pads fight the pull-ups, the latch pin turns around in self-boot.
  wire scl_w = scl_pad.oe ? 1'b0 : h_sck;
  wire latch_w = wp_pad.oe ? wp_pad.out : h_latch;
  wire mosi_w = h_latch ? hi_lvl : h_mosi;
  wire sda_w = ~sda_pad.oe;

  initial forever #4 clock = ~clock;

  cpf_host_model host (.miso(sout), .miso_oe(sout_oe), .sck(h_sck), .latch(h_latch),
    .mosi(h_mosi));

  cpf_top #(.INIT_CYCLES(INIT), .SCL_HALF_CYC(2), .BOOT_SCL_CYCLES(4), .WB_SCL_CYCLES(4)) DUT (
    .clock(clock), .srst(srst), .active_low_reset_pin(rst_pin_n), .selfboot_pin(selfboot),
    .bus_addr_select_lo(lo), .bus_addr_select_hi(mosi_w), .spi_bit_clock(scl_w),
    .spi_frame_latch(latch_w), .sda_in(sda_w), .sda_pull_low(pull), .rd_data(8'h5a),
    .mp_mode(mode), .mp_gpio_out(gout), .mp_alt_out(aout), .mp_tdm_out(tdm), .mp_in(pin_in),
    .mp_out(mp_out), .mp_oe(mp_oe), .mp_in_sync(mp_sync), .scl_pad(scl_pad),
    .sda_pad(sda_pad), .wp_pad(wp_pad), .spi_serial_out(sout), .spi_serial_out_oe(sout_oe),
    .scl_in_sync(scl_sync), .sda_in_sync(sda_sync), .i2c_addr(addr), .ctrl_spi_mode(spi_mode),
    .init_busy(busy), .eeprom_boot(boot), .eeprom_writeback(wb), .rx_byte(rxb),
    .rx_valid(rxv), .rd_req(rd_req), .frame_end(fend));

  // Collects received bytes and readback activity at falls, where outputs have settled.
  always @(negedge clock) begin
    if (rxv === 1'b1) rxq.push_back(rxb);
    if (sout_oe === 1'b1) oe_seen = 1'b1;
    if (rd_req === 1'b1) rd_cnt++;
    if (fend === 1'b1) fe_cnt++;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic stop_test();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Pin reset, then counts core cycles until initialization ends.
  task automatic t_reset();
    int n;
    n = 0;
    rst_pin_n = 1'b0;
    cyc(8);
    chk("oe_in_reset", 0, sout_oe);
    chk("busy_in_reset", 1, busy);
    rst_pin_n = 1'b1;
    while (busy !== 1'b0 && n < 200) begin
      cyc(1);
      n++;
    end
    chk("init_len", 1, n >= INIT && n <= INIT + 6);
  endtask

  task automatic t_host_mode();
    chk("rx_cleared", 0, rxb);
    chk("addr", 7'h01, addr);
    chk("boot", 0, boot);
    chk("scl_oe", 0, scl_pad.oe);
    pull = 1'b1;
    cyc(3);
    chk("sda_oe", 1, sda_pad.oe);
    pull = 1'b0;
    cyc(3);
    chk("sda_rel", 0, sda_pad.oe);
    chk("sda_sync", 1, sda_sync);
    chk("scl_oe2", 0, scl_pad.oe);
    chk("scl_sync", 1, scl_sync);
  endtask

  // A frame in I2C mode is dropped but its latch low counts; the third low selects SPI.
  task automatic t_switch();
    host.shift(32, 32'h020123a5, r);
    cyc(10);
    chk("i2c_drop", 0, rxq.size());
    host.pulse();
    cyc(8);
    chk("two_pulses", 0, spi_mode);
    host.pulse();
    cyc(8);
    chk("three_pulses", 1, spi_mode);
  endtask

  // An abandoned half byte must not shift the next frame.
  task automatic t_write();
    logic [31:0] tx;
    tx = 32'h020123a5;
    fe_cnt = 0;
    host.shift(4, 32'hf, r);
    cyc(4);
    rxq.delete();
    oe_seen = 1'b0;
    host.shift(32, tx, r);
    cyc(10);
    chk("wr_count", 4, rxq.size());
    for (int i = 0; i < 4 && i < rxq.size(); i++) begin
      chk("wr_index", i, rxq[i].index);
      chk("wr_data", tx[31-8*i -: 8], rxq[i].data);
      chk("wr_flag", 0, rxq[i].is_read);
    end
    chk("wr_no_oe", 0, oe_seen);
    chk("wr_frame_end", 2, fe_cnt);
  endtask

  task automatic t_read();
    rxq.delete();
    oe_seen = 1'b0;
    rd_cnt = 0;
    host.shift(32, 32'h03012300, r);
    cyc(10);
    chk("rd_byte", 8'h5a, r[7:0]);
    chk("rd_hdr_rel", 1, r[31:8] === 24'haaaaaa || r[31:8] === 24'h555555);
    chk("rd_oe_seen", 1, oe_seen);
    chk("rd_flag", 1, rxq.size() > 0 && rxq[0].is_read === 1'b1);
    chk("rd_req", 1, rd_cnt > 0);
    chk("rd_oe_off", 0, sout_oe);
  endtask

  // Each role of every multipurpose pin, outputs judged only where driven.
  task automatic t_mp();
    logic [11:0] eoe, eout;
    for (int m = 0; m < 4; m++) begin
      for (int j = 0; j < 12; j++) mode[j] = cpf_mp_mode_t'(m);
      eoe = (m == 1) ? 12'hfff : (m == 2) ? `CPF_MP_ALT_OUT_MASK : (m == 3) ? 12'h040 : 12'h000;
      eout = (m == 1) ? gout : (m == 2) ? aout : {5'h00, tdm, 6'h00};
      cyc(4);
      chk("mp_oe", eoe, mp_oe);
      chk("mp_out", eout & eoe, mp_out & eoe);
      chk("mp_in", pin_in, mp_sync);
    end
  endtask

  // Self-boot masters the clock, holds write protect, then writes back on a trigger rise.
  task automatic t_boot();
    int n, k;
    logic prev;
    selfboot = 1'b1;
    hi_lvl = 1'b1;
    lo = 1'b0;
    t_reset();
    chk("boot_addr", 7'h02, addr);
    chk("boot_on", 1, boot);
    chk("wp_oe", 1, wp_pad.oe);
    chk("wp_idle", 1, wp_pad.out);
    n = 0;
    k = 0;
    prev = 1'b0;
    while (boot === 1'b1 && k < 500) begin
      if (scl_pad.oe === 1'b1 && prev === 1'b0) n++;
      prev = scl_pad.oe;
      cyc(1);
      k++;
    end
    chk("scl_lows", 1, n >= 4 && n <= 5);
    hi_lvl = 1'b0;
    cyc(4);
    hi_lvl = 1'b1;
    k = 0;
    while (wb !== 1'b1 && k < 10) begin
      cyc(1);
      k++;
    end
    chk("wb_on", 1, wb);
    chk("wp_wb", 0, wp_pad.out);
    k = 0;
    while (wb === 1'b1 && k < 500) begin
      cyc(1);
      k++;
    end
    chk("wb_done", 0, wb);
    chk("wp_back", 1, wp_pad.out);
  endtask

  initial begin
    for (int j = 0; j < 12; j++) mode[j] = MP_GPIO_IN;
    oe_seen = 1'b0;
    cyc(16);
    srst = 1'b0;
    cyc(2);
    t_reset();
    t_host_mode();
    t_switch();
    t_write();
    t_read();
    t_mp();
    t_boot();
    stop_test();
  end

  // Cuts a hang short well beyond the few microseconds the tests take.
  initial begin
    #400000;
    error_cnt++;
    stop_test();
  end
endmodule
